// >>> lec_link_enh.sv
// Link enhancement control register with its transmit threshold and stream enables.
`timescale 1ns/1ps

module lec_link_enh (
	// Clock, reset and host configuration access.
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	// Serial load of the enhancement bytes.
	input  wire logic        eeprom_load,
	input  wire logic [7:0]  eeprom_enh_byte,
	input  wire logic [7:0]  eeprom_enh_hi_byte,
	// Transmit FIFO and stream status.
	input  wire logic        retries_zero,
	input  wire logic        pkt_retry,
	input  wire logic        pkt_eop_seen,
	input  wire logic [11:0] fifo_bytes,
	input  wire logic        fifo_underrun,
	input  wire logic [7:0]  cip_fmt,
	// Transmit control decisions.
	output logic      [11:0] at_thresh_bytes,
	output logic             store_fwd,
	output logic             tx_start_ok,
	output logic             pkt_corrupt,
	output logic             stamp_fix_active,
	// Enable bits seen by the stream and PHY logic.
	output logic             mpeg_stamp_fix_en,
	output logic             dv_stamp_fix_en,
	output logic             prio_arb_en,
	output logic             accel_support,
	output logic             phy_programming_allow
);

	// ==========================================================
	// Register store
	logic [31:0] reg_r;
	logic [31:0] reg_nxt;
	logic        phy_prog_r;
	logic        phy_prog_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [31:0] be_mask;
	logic [31:0] wr_mask;
	logic [31:0] load_word;
	logic [31:0] read_word;
	logic [31:0] reserved_bits;
	logic        hit;
	logic        host_write;
	logic        host_read;

	always_comb begin
		be_mask       = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
		// Only the writable fields of the enabled byte lanes may change.
		wr_mask       = be_mask & lec_pkg::LEC_WRITABLE_MASK;
		load_word     = {16'h0000, eeprom_enh_hi_byte, eeprom_enh_byte};
		hit           = (cfg_addr == lec_pkg::LEC_CFG_OFFSET);
		host_write    = cfg_wr && hit;
		host_read     = cfg_rd && hit;
		// Reserved and unassigned positions are masked on the way out as well.
		reserved_bits = ~lec_pkg::LEC_WRITABLE_MASK;
		read_word     = reg_r & ~reserved_bits;
		reg_nxt       = reg_r;
		phy_prog_nxt  = phy_prog_r;
		rdata_nxt     = rdata_r;
		if (eeprom_load) begin
			// A serial load wins over a host write in the same cycle, so the
			// loaded defaults are never mixed with half a host word.
			// Its bit 6 belongs to the host controller and goes elsewhere.
			reg_nxt      = load_word & lec_pkg::LEC_WRITABLE_MASK;
			phy_prog_nxt = eeprom_enh_byte[lec_pkg::LEC_PHYPROG_BIT];
		end else if (host_write) begin
			reg_nxt = (reg_r & ~wr_mask) | (cfg_wdata & wr_mask);
		end
		// Read data is registered and holds until the next read strobe.
		if (cfg_rd) begin
			// Other offsets belong to neighbouring registers and read as zero here.
			rdata_nxt = host_read ? read_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		// Reset leaves the threshold at its 1.7K default with every enable off.
		if (sys_rst) begin
			reg_r      <= lec_pkg::LEC_RESET_VALUE;
			phy_prog_r <= 1'b0;
			rdata_r    <= 32'h0000_0000;
		end else begin
			reg_r      <= reg_nxt;
			phy_prog_r <= phy_prog_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// ==========================================================
	// Transmit threshold and store-and-forward control
	logic [1:0]  thr_code;
	logic        thr_write;
	logic        underrun_sf_r;
	logic        underrun_sf_nxt;
	logic        sf_now;
	logic        sf_by_code;
	logic        sf_by_retries;
	logic        sf_by_retry;
	logic        sf_by_underrun;
	logic [11:0] init_bytes;
	logic [11:0] thresh_nxt;
	logic        sf_nxt;
	logic        start_nxt;
	logic        corrupt_nxt;
	logic [11:0] thresh_r;
	logic        sf_r;
	logic        start_r;
	logic        corrupt_r;

	always_comb begin
		thr_code  = reg_r[lec_pkg::LEC_THRESH_HI:lec_pkg::LEC_THRESH_LO];
		// Only a host write that reaches the threshold byte, or a serial load, clears the underrun latch.
		thr_write = host_write && cfg_be[1];
		unique case (thr_code)
			lec_pkg::LEC_THR_2K:  init_bytes = lec_pkg::LEC_BYTES_2K;
			lec_pkg::LEC_THR_1K7: init_bytes = lec_pkg::LEC_BYTES_1K7;
			lec_pkg::LEC_THR_1K:  init_bytes = lec_pkg::LEC_BYTES_1K;
			lec_pkg::LEC_THR_512: init_bytes = lec_pkg::LEC_BYTES_512;
		endcase
		// An underrun latches store-and-forward until the field is rewritten.
		// A new underrun in the same cycle as the rewrite wins, so none is lost.
		underrun_sf_nxt = underrun_sf_r;
		if (thr_write || eeprom_load) begin
			underrun_sf_nxt = 1'b0;
		end
		if (fifo_underrun) begin
			underrun_sf_nxt = 1'b1;
		end
		// Each reason for store-and-forward is kept apart to show what holds a packet.
		sf_by_code     = (thr_code == lec_pkg::LEC_THR_2K);
		sf_by_retries  = retries_zero;
		sf_by_retry    = pkt_retry;
		sf_by_underrun = underrun_sf_r;
		sf_now         = sf_by_code
			|| sf_by_retries
			|| sf_by_retry
			|| sf_by_underrun;
		// In store-and-forward the full 2K threshold is reported.
		thresh_nxt  = sf_now ? lec_pkg::LEC_BYTES_2K : init_bytes;
		sf_nxt      = sf_now;
		// Store-and-forward waits for the end-of-packet token alone.
		start_nxt   = pkt_eop_seen || (!sf_now && (fifo_bytes >= init_bytes));
		// The corrupt flag copies the underrun input one cycle later, high for as long as it was.
		corrupt_nxt = fifo_underrun;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		// Every control output lags its decision by one edge; store_fwd lags an underrun by two, one after pkt_corrupt.
		if (sys_rst) begin
			underrun_sf_r <= 1'b0;
			thresh_r      <= lec_pkg::LEC_BYTES_1K7;
			sf_r          <= 1'b0;
			start_r       <= 1'b0;
			corrupt_r     <= 1'b0;
		end else begin
			underrun_sf_r <= underrun_sf_nxt;
			thresh_r      <= thresh_nxt;
			sf_r          <= sf_nxt;
			start_r       <= start_nxt;
			corrupt_r     <= corrupt_nxt;
		end
	end

	// ==========================================================
	// Stream enhancement and link capability outputs
	logic mpeg_match;
	logic dv_match;
	logic stamp_nxt;
	logic stamp_r;

	always_comb begin
		// A stream of any other format passes through without the fix.
		mpeg_match = reg_r[lec_pkg::LEC_MPEG_BIT] && (cip_fmt == lec_pkg::LEC_FMT_MPEG);
		dv_match   = reg_r[lec_pkg::LEC_DV_BIT] && (cip_fmt == lec_pkg::LEC_FMT_DV);
		stamp_nxt  = mpeg_match || dv_match;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stamp_r <= 1'b0;
		end else begin
			stamp_r <= stamp_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// Every output is taken straight from a register so its users see clean levels.
	assign cfg_rdata             = rdata_r;
	assign at_thresh_bytes       = thresh_r;
	assign store_fwd             = sf_r;
	assign tx_start_ok           = start_r;
	assign pkt_corrupt           = corrupt_r;
	assign stamp_fix_active      = stamp_r;
	assign mpeg_stamp_fix_en     = reg_r[lec_pkg::LEC_MPEG_BIT];
	assign dv_stamp_fix_en       = reg_r[lec_pkg::LEC_DV_BIT];
	assign prio_arb_en           = reg_r[lec_pkg::LEC_PRIO_BIT];
	assign accel_support         = reg_r[lec_pkg::LEC_ACCEL_BIT];
	assign phy_programming_allow = phy_prog_r;

endmodule

// >>> lec_pkg.sv
// Package with offsets, field positions, reset values and thresholds of link enhancement control.
package lec_pkg;

	// ==========================================================
	// Register placement
	localparam logic [7:0]  LEC_CFG_OFFSET      = 8'hF4;
	localparam logic [31:0] LEC_RESET_VALUE     = 32'h0000_1000;

	// ==========================================================
	// Field positions
	localparam int          LEC_THRESH_LO       = 12;
	localparam int          LEC_THRESH_HI       = 13;
	localparam int          LEC_MPEG_BIT        = 10;
	localparam int          LEC_DV_BIT          = 8;
	localparam int          LEC_PRIO_BIT        = 7;
	localparam int          LEC_PHYPROG_BIT     = 6;
	localparam int          LEC_ACCEL_BIT       = 1;

	// Bits that software may change; every other bit reads as zero.
	localparam logic [31:0] LEC_WRITABLE_MASK   = 32'h0000_3582;

	// ==========================================================
	// Threshold field codes and their byte counts
	localparam logic [1:0]  LEC_THR_2K          = 2'b00;
	localparam logic [1:0]  LEC_THR_1K7         = 2'b01;
	localparam logic [1:0]  LEC_THR_1K          = 2'b10;
	localparam logic [1:0]  LEC_THR_512         = 2'b11;
	localparam logic [11:0] LEC_BYTES_2K        = 12'h800;
	localparam logic [11:0] LEC_BYTES_1K7       = 12'h6C0;
	localparam logic [11:0] LEC_BYTES_1K        = 12'h400;
	localparam logic [11:0] LEC_BYTES_512       = 12'h200;

	// ==========================================================
	// Isochronous CIP format codes
	localparam logic [7:0]  LEC_FMT_MPEG        = 8'h20;
	localparam logic [7:0]  LEC_FMT_DV          = 8'h00;

endpackage

// >>> lec_link_enh_chk.sv
// Checker with concurrent assertions on the link enhancement control ports.
`timescale 1ns/1ps

module lec_chk (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        cfg_wr,
	input wire logic [31:0] cfg_rdata,
	input wire logic        eeprom_load,
	input wire logic        retries_zero,
	input wire logic        pkt_retry,
	input wire logic        pkt_eop_seen,
	input wire logic        fifo_underrun,
	input wire logic [7:0]  cip_fmt,
	input wire logic [11:0] at_thresh_bytes,
	input wire logic        store_fwd,
	input wire logic        tx_start_ok,
	input wire logic        pkt_corrupt,
	input wire logic        stamp_fix_active,
	input wire logic        mpeg_stamp_fix_en,
	input wire logic        phy_programming_allow
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_rsv; (cfg_rdata & ~lec_pkg::LEC_WRITABLE_MASK) == 32'h0000_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	property p_sf_eop; store_fwd && tx_start_ok |-> $past(pkt_eop_seen); endproperty
	a_sf_eop: assert property (p_sf_eop) else $error("start without end token");
	property p_rtz; retries_zero |=> store_fwd && at_thresh_bytes == 12'h800; endproperty
	a_rtz: assert property (p_rtz) else $error("no store-and-forward");
	property p_retry; pkt_retry |=> store_fwd && at_thresh_bytes == 12'h800; endproperty
	a_retry: assert property (p_retry) else $error("retry not store-and-forward");
	property p_und; fifo_underrun |=> pkt_corrupt ##1 store_fwd; endproperty
	a_und: assert property (p_und) else $error("underrun not handled");
	property p_nocor; !fifo_underrun |=> !pkt_corrupt; endproperty
	a_nocor: assert property (p_nocor) else $error("spurious corrupt");
	property p_mpeg; mpeg_stamp_fix_en && cip_fmt == 8'h20 && !cfg_wr && !eeprom_load
		|=> stamp_fix_active; endproperty
	a_mpeg: assert property (p_mpeg) else $error("mpeg stamp fix missing");
	property p_phy; !eeprom_load |=> $stable(phy_programming_allow); endproperty
	a_phy: assert property (p_phy) else $error("phy allow changed");
	c_und: cover property (fifo_underrun ##1 pkt_corrupt);
	c_rtz: cover property (retries_zero ##1 store_fwd);
	c_fix: cover property (stamp_fix_active);
endmodule

bind lec_link_enh lec_chk i_chk (
	.core_clk              (core_clk),
	.sys_rst               (sys_rst),
	.cfg_wr                (cfg_wr),
	.cfg_rdata             (cfg_rdata),
	.eeprom_load           (eeprom_load),
	.retries_zero          (retries_zero),
	.pkt_retry             (pkt_retry),
	.pkt_eop_seen          (pkt_eop_seen),
	.fifo_underrun         (fifo_underrun),
	.cip_fmt               (cip_fmt),
	.at_thresh_bytes       (at_thresh_bytes),
	.store_fwd             (store_fwd),
	.tx_start_ok           (tx_start_ok),
	.pkt_corrupt           (pkt_corrupt),
	.stamp_fix_active      (stamp_fix_active),
	.mpeg_stamp_fix_en     (mpeg_stamp_fix_en),
	.phy_programming_allow (phy_programming_allow)
);

// >>> testbench.sv
// Self-checking testbench for the link enhancement control register.
`timescale 1ns/1ps

module testbench;
	logic        core_clk, sys_rst, cfg_wr, cfg_rd, eeprom_load, retries_zero, pkt_retry;
	logic        pkt_eop_seen, fifo_underrun, store_fwd, tx_start_ok, pkt_corrupt;
	logic        stamp_fix_active, mpeg_stamp_fix_en, dv_stamp_fix_en, prio_arb_en;
	logic        accel_support, phy_programming_allow;
	logic [7:0]  cfg_addr, eeprom_enh_byte, eeprom_enh_hi_byte, cip_fmt;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [11:0] fifo_bytes, at_thresh_bytes;
	logic [11:0] thr [4] = '{12'h800, 12'h6C0, 12'h400, 12'h200};
	int          n_errors = 0;
	int          tests_run = 0;
	lec_link_enh i_dut (
		.core_clk              (core_clk),
		.sys_rst               (sys_rst),
		.cfg_addr              (cfg_addr),
		.cfg_wr                (cfg_wr),
		.cfg_rd                (cfg_rd),
		.cfg_be                (cfg_be),
		.cfg_wdata             (cfg_wdata),
		.cfg_rdata             (cfg_rdata),
		.eeprom_load           (eeprom_load),
		.eeprom_enh_byte       (eeprom_enh_byte),
		.eeprom_enh_hi_byte    (eeprom_enh_hi_byte),
		.retries_zero          (retries_zero),
		.pkt_retry             (pkt_retry),
		.pkt_eop_seen          (pkt_eop_seen),
		.fifo_bytes            (fifo_bytes),
		.fifo_underrun         (fifo_underrun),
		.cip_fmt               (cip_fmt),
		.at_thresh_bytes       (at_thresh_bytes),
		.store_fwd             (store_fwd),
		.tx_start_ok           (tx_start_ok),
		.pkt_corrupt           (pkt_corrupt),
		.stamp_fix_active      (stamp_fix_active),
		.mpeg_stamp_fix_en     (mpeg_stamp_fix_en),
		.dv_stamp_fix_en       (dv_stamp_fix_en),
		.prio_arb_en           (prio_arb_en),
		.accel_support         (accel_support),
		.phy_programming_allow (phy_programming_allow)
	);
	always #50 core_clk = ~core_clk;
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stp(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge core_clk);
		cfg_addr  <= a;
		cfg_be    <= b;
		cfg_wdata <= d;
		cfg_wr    <= 1'b1;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		stp(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		cfg_addr <= a; cfg_rd <= 1'b1;
		@(posedge core_clk);
		cfg_rd <= 1'b0;
		#1;
		chk(cfg_rdata, e);
	endtask
	task automatic end_sim();
		$display("errors=%0d checks=%0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		#100000;
		n_errors++;
		end_sim();
	end
	initial begin
		core_clk           = 1'b0;
		sys_rst            = 1'b1;
		cfg_wr             = 1'b0;
		cfg_rd             = 1'b0;
		eeprom_load        = 1'b0;
		retries_zero       = 1'b0;
		pkt_retry          = 1'b0;
		pkt_eop_seen       = 1'b0;
		fifo_underrun      = 1'b0;
		cfg_addr           = 8'hF4;
		cfg_be             = 4'h0;
		cfg_wdata          = 32'h0000_0000;
		eeprom_enh_byte    = 8'hFF;
		eeprom_enh_hi_byte = 8'hFF;
		cip_fmt            = 8'h20;
		fifo_bytes         = 12'hFFF;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'hF4, 32'h0000_1000);
		chk(at_thresh_bytes, 12'h6C0);
		wr(8'hF4, 4'hF, 32'hFFFF_FFFF);
		rd(8'hF4, 32'h0000_3582);
		chk({mpeg_stamp_fix_en, dv_stamp_fix_en, prio_arb_en, accel_support}, 4'hF);
		chk(stamp_fix_active, 1'b1);
		@(posedge core_clk) cip_fmt <= 8'h00;
		stp(1);
		chk(stamp_fix_active, 1'b1);
		@(posedge core_clk) cip_fmt <= 8'h33;
		stp(1);
		chk(stamp_fix_active, 1'b0);
		$display("test fields done");
		for (int i = 0; i < 4; i++) begin
			wr(8'hF4, 4'h3, 32'(i) << 12);
			chk(at_thresh_bytes, thr[i]);
			chk(tx_start_ok, i != 0);
		end
		chk({mpeg_stamp_fix_en, dv_stamp_fix_en, prio_arb_en, accel_support}, 4'h0);
		@(posedge core_clk) retries_zero <= 1'b1;
		stp(1);
		chk({store_fwd, at_thresh_bytes}, 13'h1800);
		@(posedge core_clk) {retries_zero, pkt_retry} <= 2'b01;
		stp(1);
		chk({store_fwd, at_thresh_bytes}, 13'h1800);
		@(posedge core_clk) {pkt_retry, fifo_underrun} <= 2'b01;
		@(posedge core_clk) fifo_underrun <= 1'b0;
		#1 chk(pkt_corrupt, 1'b1);
		stp(1);
		chk({pkt_corrupt, store_fwd, tx_start_ok}, 3'b010);
		@(posedge core_clk) pkt_eop_seen <= 1'b1;
		stp(1);
		chk(tx_start_ok, 1'b1);
		wr(8'hF4, 4'h2, 32'h0000_3000);
		chk(store_fwd, 1'b0);
		$display("test threshold done");
		@(posedge core_clk) eeprom_load <= 1'b1;
		@(posedge core_clk) eeprom_load <= 1'b0;
		stp(1);
		chk(phy_programming_allow, 1'b1);
		wr(8'hF8, 4'hF, 32'h0000_0000);
		rd(8'hF4, 32'h0000_3582);
		rd(8'hF8, 32'h0000_0000);
		$display("test load done");
		end_sim();
	end
endmodule
